/* File: design/crccs_pkg.sv */
package crccs_pkg;

    // Register byte offsets on the Avalon-MM slave
    localparam logic [4:0] CRCCS_OFF_CONTROL = 5'h00;
    localparam logic [4:0] CRCCS_OFF_LENGTH = 5'h04;
    localparam logic [4:0] CRCCS_OFF_POLY = 5'h08;
    localparam logic [4:0] CRCCS_OFF_DATA = 5'h0C;
    localparam logic [4:0] CRCCS_OFF_RESULT = 5'h10;

    // Control register field positions
    localparam int CRCCS_BIT_ENABLE = 15;
    localparam int CRCCS_BIT_STOP_IDLE = 13;
    localparam int CRCCS_POS_COUNT = 8;
    localparam int CRCCS_BIT_FULL = 7;
    localparam int CRCCS_BIT_EMPTY = 6;
    localparam int CRCCS_BIT_IRQ_SEL = 5;
    localparam int CRCCS_BIT_START = 4;
    localparam int CRCCS_BIT_LSB = 3;

    // Widths and depths
    localparam int CRCCS_WORD_W = 32;
    localparam int CRCCS_CRC_W = 16;
    localparam int CRCCS_FIFO_DEPTH = 16;
    localparam logic [4:0] CRCCS_CAP_SHORT = 5'h10;
    localparam logic [4:0] CRCCS_CAP_LONG = 5'h08;
    localparam logic [4:0] CRCCS_SHORT_MAX_LEN = 5'h07;

    // Values after reset
    localparam logic [4:0] CRCCS_RST_LENGTH = 5'h07;
    localparam logic [15:0] CRCCS_RST_POLY = 16'h0000;
    localparam logic [15:0] CRCCS_RST_RESULT = 16'h0000;

    typedef struct packed {
        logic module_enable;
        logic stop_in_idle;
        logic irq_condition_select;
        logic shifter_start;
        logic lsb_first_select;
    } crccs_ctrl_s;

    localparam crccs_ctrl_s CRCCS_RST_CTRL = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

    typedef struct packed {
        logic [4:0] valid_word_count;
        logic fifo_full_flag;
        logic fifo_empty_flag;
    } crccs_stat_s;

endpackage

/* File: design/crccs_buf2.sv */
`timescale 1ns/100ps
`default_nettype none

// Two-entry buffer; holds a word while the consumer stalls
module crccs_buf2 #(
    parameter int W = 32
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] slot [2];
    logic [1:0] fill;
    logic wr_idx;
    logic rd_idx;
    logic push;
    logic pop;

    assign in_ready = (fill != 2'h2);
    assign out_valid = (fill != 2'h0);
    assign out_data = slot[rd_idx];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fill <= 2'h0;
            wr_idx <= 1'b0;
            rd_idx <= 1'b0;
        end else if (clear) begin
            fill <= 2'h0;
            wr_idx <= 1'b0;
            rd_idx <= 1'b0;
        end else begin
            if (push) begin
                wr_idx <= ~wr_idx;
            end
            if (pop) begin
                rd_idx <= ~rd_idx;
            end
            fill <= fill + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            slot[wr_idx] <= in_data;
        end
    end
endmodule // crccs_buf2

`default_nettype wire

/* File: design/crccs_top.sv */
// Notes on behaviour
// [R1] Stop-in-idle set freezes CRC work while the device idles; clear keeps running.
// [R2] Five-bit count of FIFO words; limit 8 if length above 7, else 16.
// [R3] Full flag is 1 while FIFO full, else 0; resets to 0.
// [R4] Empty flag is 1 while FIFO holds nothing, else 0; resets to 1.
// [R5] Select 1: event when FIFO empties; select 0: event when result ready.
// [R6] Start bit 1 runs the serial shifter on FIFO words; 0 stops it.
// [R7] Bit order select 1 shifts data LSB first; 0 shifts MSB first.
// [R8] Enable clear holds FIFO, shifter and result in reset; set runs normally.
`timescale 1ns/100ps
`default_nettype none

module crccs_top (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic device_idle,
    output logic crc_event
);
    import crccs_pkg::*;

    crccs_ctrl_s ctrl;
    crccs_stat_s stat;
    logic [4:0] data_length_setting;
    logic [15:0] poly;
    logic [15:0] result_word_register;
    logic rd_ack;
    logic sel_ctrl;
    logic sel_len;
    logic sel_poly;
    logic sel_data;
    logic sel_result;
    logic wr_take;
    logic [15:0] wmask;
    logic [15:0] next_ctrl_word;

    logic buf_in_valid;
    logic buf_in_ready;
    logic buf_out_valid;
    logic buf_out_ready;
    logic [CRCCS_WORD_W-1:0] buf_out_data;

    logic [CRCCS_WORD_W-1:0] fifo_mem [CRCCS_FIFO_DEPTH];
    logic [3:0] wp;
    logic [3:0] rp;
    logic [4:0] cnt;
    logic [4:0] cap;
    logic fifo_push;
    logic fifo_pop;

    logic run;
    logic busy;
    logic [CRCCS_WORD_W-1:0] sh_word;
    logic [4:0] bit_idx;
    logic [4:0] bits_left;
    logic in_bit;
    logic feedback;
    logic shift_done;

    // Address decode
    assign sel_ctrl = (avs_address == CRCCS_OFF_CONTROL);
    assign sel_len = (avs_address == CRCCS_OFF_LENGTH);
    assign sel_poly = (avs_address == CRCCS_OFF_POLY);
    assign sel_data = (avs_address == CRCCS_OFF_DATA);
    assign sel_result = (avs_address == CRCCS_OFF_RESULT);
    assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // Data writes stall only while the input buffer is full
    assign avs_waitrequest = (avs_read & ~rd_ack)
        | (avs_write & sel_data & ctrl.module_enable & ~buf_in_ready);
    assign wr_take = avs_write & ~avs_waitrequest;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_ack <= 1'b0;
        end else begin
            rd_ack <= avs_read & ~rd_ack;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read & ~rd_ack) begin
            if (sel_ctrl) begin
                avs_readdata <= {16'h0000, ctrl.module_enable, 1'b0, ctrl.stop_in_idle,
                    stat.valid_word_count, stat.fifo_full_flag, stat.fifo_empty_flag,
                    ctrl.irq_condition_select, ctrl.shifter_start,
                    ctrl.lsb_first_select, 3'h0};
            end else if (sel_len) begin
                avs_readdata <= {27'h0000000, data_length_setting};
            end else if (sel_poly) begin
                avs_readdata <= {16'h0000, poly};
            end else if (sel_result) begin
                avs_readdata <= {16'h0000, result_word_register};
            end else begin
                avs_readdata <= 32'h00000000;
            end
        end
    end

    // Control register; status fields ignore writes
    always_comb begin
        next_ctrl_word = {ctrl.module_enable, 1'b0, ctrl.stop_in_idle, 7'h00,
            ctrl.irq_condition_select, ctrl.shifter_start, ctrl.lsb_first_select, 3'h0};
        next_ctrl_word = (next_ctrl_word & ~wmask) | (avs_writedata[15:0] & wmask);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= CRCCS_RST_CTRL;
        end else if (wr_take & sel_ctrl) begin
            ctrl.module_enable <= next_ctrl_word[CRCCS_BIT_ENABLE];
            ctrl.stop_in_idle <= next_ctrl_word[CRCCS_BIT_STOP_IDLE];
            ctrl.irq_condition_select <= next_ctrl_word[CRCCS_BIT_IRQ_SEL];
            ctrl.shifter_start <= next_ctrl_word[CRCCS_BIT_START]; // [R6]
            ctrl.lsb_first_select <= next_ctrl_word[CRCCS_BIT_LSB]; // [R7]
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            data_length_setting <= CRCCS_RST_LENGTH;
            poly <= CRCCS_RST_POLY;
        end else if (wr_take) begin
            if (sel_len & avs_byteenable[0]) begin
                data_length_setting <= avs_writedata[4:0];
            end
            if (sel_poly) begin
                poly <= (poly & ~wmask) | (avs_writedata[15:0] & wmask);
            end
        end
    end

    // Input buffer between the bus and the FIFO
    assign buf_in_valid = wr_take & sel_data & ctrl.module_enable;
    assign buf_out_ready = ctrl.module_enable & (cnt < cap);

    crccs_buf2 #(
        .W(CRCCS_WORD_W)
    ) u_inbuf (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clear(~ctrl.module_enable), // [R8]
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .in_data(avs_writedata),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(buf_out_data)
    );

    // FIFO capacity follows the data length
    assign cap = (data_length_setting > CRCCS_SHORT_MAX_LEN) ? CRCCS_CAP_LONG
        : CRCCS_CAP_SHORT; // [R2]
    assign fifo_push = buf_out_valid & buf_out_ready;
    assign run = ctrl.module_enable & ctrl.shifter_start
        & ~(ctrl.stop_in_idle & device_idle); // [R1] [R6]
    assign fifo_pop = run & ~busy & (cnt != 5'h00);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wp <= 4'h0;
            rp <= 4'h0;
            cnt <= 5'h00;
        end else if (!ctrl.module_enable) begin
            wp <= 4'h0; // [R8]
            rp <= 4'h0;
            cnt <= 5'h00;
        end else begin
            if (fifo_push) begin
                wp <= wp + 4'h1;
            end
            if (fifo_pop) begin
                rp <= rp + 4'h1;
            end
            cnt <= cnt + {4'h0, fifo_push} - {4'h0, fifo_pop}; // [R2]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (fifo_push) begin
            fifo_mem[wp] <= buf_out_data;
        end
    end

    assign stat.valid_word_count = cnt; // [R2]
    assign stat.fifo_full_flag = (cnt == cap); // [R3]
    assign stat.fifo_empty_flag = (cnt == 5'h00); // [R4]

    // Serial shifter, one data bit per clock
    assign in_bit = sh_word[bit_idx];
    assign feedback = result_word_register[CRCCS_CRC_W-1] ^ in_bit;
    assign shift_done = busy & run & (bits_left == 5'h00);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            sh_word <= 32'h00000000;
            bit_idx <= 5'h00;
            bits_left <= 5'h00;
        end else if (!ctrl.module_enable) begin
            busy <= 1'b0; // [R8]
            sh_word <= 32'h00000000;
            bit_idx <= 5'h00;
            bits_left <= 5'h00;
        end else if (fifo_pop) begin
            busy <= 1'b1;
            sh_word <= fifo_mem[rp];
            bit_idx <= ctrl.lsb_first_select ? 5'h00 : data_length_setting; // [R7]
            bits_left <= data_length_setting;
        end else if (busy & run) begin
            bits_left <= bits_left - 5'h01;
            bit_idx <= ctrl.lsb_first_select ? bit_idx + 5'h01 : bit_idx - 5'h01; // [R7]
            if (bits_left == 5'h00) begin
                busy <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            result_word_register <= CRCCS_RST_RESULT;
        end else if (!ctrl.module_enable) begin
            result_word_register <= CRCCS_RST_RESULT; // [R8]
        end else if (wr_take & sel_result) begin
            result_word_register <= (result_word_register & ~wmask)
                | (avs_writedata[15:0] & wmask);
        end else if (busy & run) begin
            result_word_register <= {result_word_register[CRCCS_CRC_W-2:0], 1'b0}
                ^ (feedback ? poly : 16'h0000);
        end
    end

    // Completion event pulse
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            crc_event <= 1'b0;
        end else if (ctrl.irq_condition_select) begin
            crc_event <= fifo_pop & (cnt == 5'h01) & ~fifo_push; // [R5]
        end else begin
            crc_event <= shift_done & (cnt == 5'h00) & ~fifo_push; // [R5]
        end
    end

    sequence s_last_pop;
        ctrl.irq_condition_select && fifo_pop && cnt == 5'h01 && !fifo_push;
    endsequence

    sequence s_last_shift;
        !ctrl.irq_condition_select && shift_done && cnt == 5'h00 && !fifo_push;
    endsequence

    chk_empty_flag: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R4]
        !ctrl.module_enable |=> stat.fifo_empty_flag && stat.valid_word_count == 5'h00)
        else $error("FIFO not empty after disable");

    chk_full_flag: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R3]
        stat.fifo_full_flag |-> !buf_out_ready && cnt == cap)
        else $error("Full flag disagrees with FIFO");

    chk_count_cap: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R2]
        stat.valid_word_count <= cap || $past(cap) != cap)
        else $error("Word count above capacity");

    chk_idle_stop: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R1]
        ctrl.module_enable && ctrl.stop_in_idle && device_idle && busy
        && !(wr_take && (sel_ctrl || sel_result))
        |=> $stable(result_word_register))
        else $error("Shifter ran while stopped in idle");

    chk_start_off: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R6]
        !ctrl.shifter_start && ctrl.module_enable |=> $stable(rp))
        else $error("FIFO drained with shifter off");

    chk_lsb_order: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R7]
        fifo_pop && ctrl.lsb_first_select |=> bit_idx == 5'h00 && busy)
        else $error("LSB-first start bit wrong");

    chk_msb_order: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R7]
        fifo_pop && !ctrl.lsb_first_select |=> bit_idx == $past(data_length_setting))
        else $error("MSB-first start bit wrong");

    chk_irq_empty: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R5]
        s_last_pop |=> crc_event ##1 !crc_event)
        else $error("Empty event missing");

    chk_irq_done: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R5]
        s_last_shift |=> crc_event && !busy)
        else $error("Done event missing");

    chk_disable_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R8]
        !ctrl.module_enable ##1 !ctrl.module_enable
        |-> !busy && result_word_register == CRCCS_RST_RESULT)
        else $error("Block not held in reset while disabled");

endmodule // crccs_top

`default_nettype wire

/* File: verif/crccs_top_test.sv */
`timescale 1ns/100ps
`default_nettype none

module crccs_top_test;
    import crccs_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic device_idle = 1'b0;
    logic crc_event;
    int n_mismatch = 0;
    int n_tests = 0;
    int n_event = 0;
    int n_cyc = 0;
    logic [31:0] rd;
    logic [31:0] words [18];

    always #12.5 clk_sys = ~clk_sys;

    crccs_top u_dut (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .device_idle(device_idle),
        .crc_event(crc_event)
    );

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Completion pulses and hang guard
    always @(posedge clk_sys) begin
        n_cyc <= n_cyc + 1;
        if (crc_event === 1'b1) begin
            n_event <= n_event + 1;
        end
        if (n_cyc == 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    // One Avalon transfer; idle edge first so strobes never toggle twice per step
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    function automatic logic [31:0] ctl(input logic [15:0] c, input int n, input int cap);
        return {16'h0, c[15], 1'b0, c[13], 5'(n), n == cap, n == 0, c[5:3], 3'b000};
    endfunction

    function automatic logic [15:0] crc_of(input int n, input logic [4:0] len,
                                           input logic [15:0] poly, input logic lsb);
        logic [15:0] c;
        logic b;
        c = 16'h0;
        for (int i = 0; i < n; i++) begin
            for (int j = 0; j <= len; j++) begin
                b = words[i][lsb ? j : len - j];
                c = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? poly : 16'h0);
            end
        end
        return c;
    endfunction

    // Fill FIFO plus buffer, optionally hold in idle, then drain and check
    task automatic run(input logic [4:0] len, input logic lsb, input logic sel,
                       input logic stop);
        int cap;
        int e0;
        logic [15:0] poly;
        logic [15:0] c;
        cap = (len > 5'h07) ? 8 : 16;
        poly = 16'($urandom);
        c = 16'h8000 | {2'b00, stop, 7'h00, sel, 1'b0, lsb, 3'h0};
        device_idle <= 1'b1;
        bus(1'b1, CRCCS_OFF_CONTROL, 32'h0);
        bus(1'b1, CRCCS_OFF_LENGTH, {27'h0, len});
        bus(1'b1, CRCCS_OFF_POLY, {16'h0, poly});
        bus(1'b1, CRCCS_OFF_CONTROL, {16'h0, c});
        bus(1'b1, CRCCS_OFF_RESULT, 32'h0);
        for (int i = 0; i < cap + 2; i++) begin
            words[i] = $urandom;
            bus(1'b1, CRCCS_OFF_DATA, words[i]);
        end
        repeat (4) @(posedge clk_sys);
        rdchk(CRCCS_OFF_CONTROL, ctl(c, cap, cap));
        e0 = n_event;
        c = c | 16'h0010;
        bus(1'b1, CRCCS_OFF_CONTROL, {16'h0, c});
        if (stop) begin
            repeat (50) @(posedge clk_sys);
            rdchk(CRCCS_OFF_CONTROL, ctl(c, cap, cap));
            device_idle <= 1'b0;
            // Re-enter idle mid-word; shifter must freeze, then resume
            repeat (3) @(posedge clk_sys);
            device_idle <= 1'b1;
            repeat (20) @(posedge clk_sys);
            device_idle <= 1'b0;
        end
        for (int k = 0; k < 2000 && n_event == e0; k++) begin
            @(posedge clk_sys);
        end
        repeat (int'(len) + 4) @(posedge clk_sys);
        rdchk(CRCCS_OFF_CONTROL, ctl(c, 0, cap));
        rdchk(CRCCS_OFF_RESULT, {16'h0, crc_of(cap + 2, len, poly, lsb)});
        chk(32'(n_event - e0), 32'h1);
    endtask

    initial begin
        void'($urandom(32'h5dea));
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rdchk(CRCCS_OFF_CONTROL, 32'h0040);
        rdchk(CRCCS_OFF_LENGTH, {27'h0, CRCCS_RST_LENGTH});
        rdchk(CRCCS_OFF_POLY, {16'h0, CRCCS_RST_POLY});
        rdchk(CRCCS_OFF_RESULT, {16'h0, CRCCS_RST_RESULT});
        bus(1'b1, 5'h14, 32'hFFFF_FFFF);
        rdchk(5'h14, 32'h0);
        bus(1'b1, CRCCS_OFF_CONTROL, 32'h0000_FFFF);
        rdchk(CRCCS_OFF_CONTROL, 32'h0000_A078);
        // Low lane only: upper control bits must keep their values
        avs_byteenable <= 4'h1;
        bus(1'b1, CRCCS_OFF_CONTROL, 32'h0000_0000);
        rdchk(CRCCS_OFF_CONTROL, 32'h0000_A040);
        avs_byteenable <= 4'hF;
        // Boundary lengths first, then random ones
        for (int k = 0; k < 6; k++) begin
            run(k == 0 ? 5'h07 : k == 1 ? 5'h08 : 5'($urandom_range(31, 0)),
                k[1], k[0] ^ k[1], k[1] ^ k[2]);
        end
        bus(1'b1, CRCCS_OFF_CONTROL, 32'h0000_8000);
        bus(1'b1, CRCCS_OFF_RESULT, 32'h0000_1234);
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, CRCCS_OFF_DATA, $urandom);
        end
        repeat (4) @(posedge clk_sys);
        rdchk(CRCCS_OFF_CONTROL, 32'h0000_8300);
        bus(1'b1, CRCCS_OFF_CONTROL, 32'h0);
        rdchk(CRCCS_OFF_CONTROL, 32'h0000_0040);
        rdchk(CRCCS_OFF_RESULT, 32'h0);
        bus(1'b1, CRCCS_OFF_DATA, $urandom);
        bus(1'b1, CRCCS_OFF_CONTROL, 32'h0000_8000);
        repeat (4) @(posedge clk_sys);
        rdchk(CRCCS_OFF_CONTROL, 32'h0000_8040);
        wrap_up();
    end
endmodule // crccs_top_test

`default_nettype wire
